// File: verilog/mpsrc_params.svh
`ifndef MPSRC_PARAMS_SVH
`define MPSRC_PARAMS_SVH

// Register indices; byte address is four times the index
`define MPSRC_IDX_BOARD 8'h1d
`define MPSRC_IDX_ROM 8'h1e
`define MPSRC_IDX_NONE 8'hff

// serial_rom_control bit positions
`define MPSRC_ROM_ACK 7
`define MPSRC_ROM_REQ 6
`define MPSRC_ROM_SEL 5
`define MPSRC_ROM_RDY 4
`define MPSRC_ROM_CS 3
`define MPSRC_ROM_CK 2
`define MPSRC_ROM_DO 1
`define MPSRC_ROM_DI 0

// board_logic_control bit positions
`define MPSRC_BRD_DAT_HI 7
`define MPSRC_BRD_DAT_LO 5
`define MPSRC_BRD_STB 4
`define MPSRC_BRD_CS 3
`define MPSRC_BRD_DIR 2

// Reset values
`define MPSRC_BOARD_RST 8'h00
`define MPSRC_ROM_RST 8'h00
`define MPSRC_SYNC_RST 9'h1ff

// Ready timer
`define MPSRC_CLK_NS 10
`define MPSRC_READY_NS 800
`define MPSRC_READY_CYC \
  ((`MPSRC_READY_NS + `MPSRC_CLK_NS - 1) / `MPSRC_CLK_NS)

`endif

// File: verilog/mpsrc_pkg.sv
package mpsrc_pkg;
  // Port arbitration states
  typedef enum logic [1:0]
  {
    MPSRC_IDLE = 2'b00,
    MPSRC_REQ = 2'b01,
    MPSRC_GRANT = 2'b10
  } mpsrc_arb_t;

  // AXI response codes
  typedef enum logic [1:0]
  {
    MPSRC_OKAY = 2'b00,
    MPSRC_SLVERR = 2'b10
  } mpsrc_resp_t;
endpackage

// File: verilog/mpsrc_regbus_if.sv
interface mpsrc_regbus_if;
  logic wrEn;
  logic [7:0] wrIdx;
  logic [7:0] wrData;
  logic wrByte;
  logic wrHit;
  logic rdEn;
  logic [7:0] rdIdx;
  logic [7:0] rdData;
  logic rdHit;

  modport slave
  (
    output wrEn, wrIdx, wrData, wrByte, rdEn, rdIdx,
    input wrHit, rdData, rdHit
  );
  modport core
  (
    input wrEn, wrIdx, wrData, wrByte, rdEn, rdIdx,
    output wrHit, rdData, rdHit
  );
endinterface

// File: verilog/mpsrc_sync.sv
module mpsrc_sync
#(
  parameter int W = 9
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_r;

  // Two flops per bit; the first is read only by the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          stage1_r[i] <= 1'b1;
          syncOut[i] <= 1'b1;
        end
        else
        begin
          stage1_r[i] <= asyncIn[i];
          syncOut[i] <= stage1_r[i];
        end
      end
    end
  endgenerate
endmodule

// File: verilog/mpsrc_axil.sv
`include "mpsrc_params.svh"

module mpsrc_axil
  import mpsrc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Write address and data
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output mpsrc_pkg::mpsrc_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // Read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output mpsrc_pkg::mpsrc_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  mpsrc_regbus_if.slave bus
);
  logic [7:0] wrIdx_r;
  logic [7:0] rdIdx_r;
  logic [7:0] wData_r;
  logic wByte_r;
  logic awTaken;
  logic wTaken;
  logic arTaken;
  logic [7:0] awIdx;
  logic [7:0] arIdx;

  // Addresses beyond the low window map to an unused index
  assign awIdx = (awaddr[11:10] == 2'b00) ? awaddr[9:2] : `MPSRC_IDX_NONE;
  assign arIdx = (araddr[11:10] == 2'b00) ? araddr[9:2] : `MPSRC_IDX_NONE;
  assign awTaken = awvalid && awready;
  assign wTaken = wvalid && wready;
  assign arTaken = arvalid && arready;
  assign bus.wrIdx = wrIdx_r;
  assign bus.wrData = wData_r;
  assign bus.wrByte = wByte_r;
  assign bus.rdIdx = rdIdx_r;
  // Write fires once both halves are held and no response pends
  assign bus.wrEn = !awready && !wready && !bvalid;
  assign bus.rdEn = !arready && !rvalid;

  // Write channels, taken in either order
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= MPSRC_OKAY;
      wrIdx_r <= 8'h00;
      wData_r <= 8'h00;
      wByte_r <= 1'b0;
    end
    else
    begin
      if (awTaken)
      begin
        awready <= 1'b0;
        wrIdx_r <= awIdx;
      end
      if (wTaken)
      begin
        wready <= 1'b0;
        wData_r <= wdata[7:0];
        wByte_r <= wstrb[0];
      end
      if (bus.wrEn)
      begin
        bvalid <= 1'b1;
        bresp <= bus.wrHit ? MPSRC_OKAY : MPSRC_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel; data sits in the low byte
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= MPSRC_OKAY;
      rdIdx_r <= 8'h00;
    end
    else if (arTaken)
    begin
      arready <= 1'b0;
      rdIdx_r <= arIdx;
    end
    else if (bus.rdEn)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, bus.rdData};
      rresp <= bus.rdHit ? MPSRC_OKAY : MPSRC_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// File: verilog/mport_serial_rom_board_ctl.sv
`include "mpsrc_params.svh"

module mport_serial_rom_board_ctl
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output mpsrc_pkg::mpsrc_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output mpsrc_pkg::mpsrc_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // Other memory-port users, same clock
  input wire logic sramRomBusy,
  // External arbitration pins, active low
  input wire logic extGrantAckN,
  output logic extGrantRequestN,
  // Memory-port lines
  input wire logic [7:0] mportIn,
  output logic [7:0] mportOut,
  output logic [7:0] mportOe,
  output logic mportParityOut,
  output logic mportParityOe,
  // Serial ROM chip select
  output logic romSelectOut,
  output logic romSelectOe
);
  import mpsrc_pkg::*;

  localparam logic [6:0] READY_CYC = 7'(`MPSRC_READY_CYC);

  mpsrc_regbus_if bus();

  mpsrc_arb_t state_r;
  mpsrc_arb_t state_nxt;
  logic reqSel_r;
  logic romCs_r;
  logic romCk_r;
  logic romDo_r;
  logic [2:0] brdData_r;
  logic board_strobe_r;
  logic board_select_r;
  logic brdDir_r;
  logic [6:0] readyCnt_r;
  logic [6:0] readyCnt_nxt;
  logic [8:0] syncVal;
  logic ackSync;
  logic [7:0] mportSync;
  logic granted;
  logic portReady;
  logic romWrite;
  logic boardWrite;
  logic [7:0] romRead;
  logic [7:0] boardRead;
  logic [2:0] brdDataRead;
  logic [7:0] mportOut_nxt;
  logic [7:0] mportOe_nxt;

  // Register bus slave
  mpsrc_axil u_axil
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .bus(bus)
  );

  // Acknowledge and port lines come from outside the clock domain
  mpsrc_sync #(.W(9)) u_sync
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn({extGrantAckN, mportIn}),
    .syncOut(syncVal)
  );

  assign ackSync = syncVal[8];
  assign mportSync = syncVal[7:0];

  // Address decode
  assign romWrite = bus.wrEn && (bus.wrIdx == `MPSRC_IDX_ROM);
  assign boardWrite = bus.wrEn && bus.wrByte
    && (bus.wrIdx == `MPSRC_IDX_BOARD);
  assign bus.wrHit = (bus.wrIdx == `MPSRC_IDX_ROM)
    || (bus.wrIdx == `MPSRC_IDX_BOARD);
  assign bus.rdHit = (bus.rdIdx == `MPSRC_IDX_ROM)
    || (bus.rdIdx == `MPSRC_IDX_BOARD);

  // Arbitration; ownership held until software drops the request
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MPSRC_IDLE:
        if (reqSel_r && !sramRomBusy)
          state_nxt = MPSRC_REQ;
      MPSRC_REQ:
        if (!reqSel_r)
          state_nxt = MPSRC_IDLE;
        else if (!ackSync)
          state_nxt = MPSRC_GRANT;
      MPSRC_GRANT:
        if (!reqSel_r)
          state_nxt = MPSRC_IDLE;
      default:
        state_nxt = MPSRC_IDLE;
    endcase
  end

  assign granted = (state_r == MPSRC_GRANT) && reqSel_r;

  // Timer restarts on every serial ROM control write, even ones that change nothing
  assign readyCnt_nxt = romWrite ? READY_CYC
    : (readyCnt_r != 7'h00) ? readyCnt_r - 7'h01 : readyCnt_r;
  // While requested, ready also waits for the grant
  assign portReady = (readyCnt_r == 7'h00)
    && (!reqSel_r || (state_r == MPSRC_GRANT));

  // Pin values; active-low board lines invert the register bits
  assign mportOut_nxt = {brdData_r, ~board_strobe_r, ~board_select_r,
    romCk_r && reqSel_r, romDo_r && reqSel_r, 1'b0};
  assign mportOe_nxt = granted ? {{3{~brdDir_r}}, 5'b1_1110}
    : 8'h00;

  // Read-back; data bits show pins only when reading the board
  assign brdDataRead = (granted && brdDir_r) ? mportSync[7:5]
    : brdData_r;
  assign romRead = {ackSync, extGrantRequestN, reqSel_r, portReady,
    romCs_r, romCk_r, romDo_r, reqSel_r && mportSync[0]};
  assign boardRead = {brdDataRead, board_strobe_r, board_select_r, brdDir_r,
    2'b00};
  assign bus.rdData = (bus.rdIdx == `MPSRC_IDX_ROM) ? romRead
    : (bus.rdIdx == `MPSRC_IDX_BOARD) ? boardRead : 8'h00;

  // Arbitration state and timer
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r <= MPSRC_IDLE;
      readyCnt_r <= 7'h00;
      extGrantRequestN <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      readyCnt_r <= readyCnt_nxt;
      extGrantRequestN <= (state_nxt == MPSRC_IDLE);
    end
  end

  // Serial ROM control bits; read-only bits are not stored
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {reqSel_r, romCs_r, romCk_r, romDo_r} <= 4'h0;
    end
    else if (romWrite && bus.wrByte)
    begin
      reqSel_r <= bus.wrData[`MPSRC_ROM_SEL];
      romCs_r <= bus.wrData[`MPSRC_ROM_CS];
      romCk_r <= bus.wrData[`MPSRC_ROM_CK];
      romDo_r <= bus.wrData[`MPSRC_ROM_DO];
    end
  end

  // Board control bits; bits 1..0 have no storage
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {brdData_r, board_strobe_r, board_select_r, brdDir_r} <= 6'h00;
    end
    else if (boardWrite)
    begin
      brdData_r <= bus.wrData[`MPSRC_BRD_DAT_HI:`MPSRC_BRD_DAT_LO];
      board_strobe_r <= bus.wrData[`MPSRC_BRD_STB];
      board_select_r <= bus.wrData[`MPSRC_BRD_CS];
      brdDir_r <= bus.wrData[`MPSRC_BRD_DIR];
    end
  end

  // Pin drivers; one cycle behind the registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mportOut <= 8'h00;
      mportOe <= 8'h00;
      mportParityOut <= 1'b0;
      mportParityOe <= 1'b0;
      romSelectOut <= 1'b0;
      romSelectOe <= 1'b0;
    end
    else
    begin
      mportOut <= mportOut_nxt;
      mportOe <= mportOe_nxt;
      mportParityOut <= brdDir_r;
      mportParityOe <= granted;
      romSelectOut <= romCs_r && granted;
      romSelectOe <= granted;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_ack_in_req;
    state_r == MPSRC_REQ && reqSel_r && !ackSync;
  endsequence

  sequence s_drive_lines;
    state_r == MPSRC_GRANT ##1 mportOe[4:1] == 4'hf && romSelectOe;
  endsequence

  a_req_asserted: assert property (
    state_r == MPSRC_IDLE && reqSel_r && !sramRomBusy
    |=> !extGrantRequestN ##1 !extGrantRequestN || !reqSel_r)
    else $error("grant request not raised");

  a_grant_drives: assert property (
    s_ack_in_req |=> s_drive_lines or !reqSel_r)
    else $error("grant did not hand lines to the port");

  a_grant_held: assert property (
    state_r == MPSRC_GRANT && reqSel_r |=> !extGrantRequestN
      && state_r == MPSRC_GRANT)
    else $error("port given up while still requested");

  a_timer_restart: assert property (
    romWrite && !bus.wrData[`MPSRC_ROM_SEL]
    |=> !portReady ##80 portReady || romWrite || $past(romWrite)
      || reqSel_r)
    else $error("ready timer not 800 ns");

  a_timer_counts: assert property (
    readyCnt_r != 7'h00 && !romWrite
    |=> readyCnt_r == $past(readyCnt_r) - 7'h01)
    else $error("ready timer stalled");

  a_ready_waits: assert property (
    reqSel_r && state_r != MPSRC_GRANT |-> !portReady)
    else $error("ready before grant");

  a_lines_released: assert property (
    state_r != MPSRC_GRANT |=> mportOe == 8'h00 && !mportParityOe
      && !romSelectOe)
    else $error("lines driven without grant");

  a_cs_gated: assert property (
    romSelectOut |-> $past(granted) && $past(romCs_r))
    else $error("chip select without arbitration");

  a_shift_clk: assert property (
    granted && romCk_r |=> mportOut[2] && mportOe[2])
    else $error("shift clock line not high");

  a_data_out: assert property (
    granted && !romDo_r |=> !mportOut[1] && mportOe[1])
    else $error("data out line wrong");

  a_serial_in: assert property (
    bus.rdEn && bus.rdIdx == `MPSRC_IDX_ROM && reqSel_r
    |-> bus.rdData[0] == mportSync[0])
    else $error("serial input not returned");

  a_status_bits: assert property (
    bus.rdEn && bus.rdIdx == `MPSRC_IDX_ROM
    |-> bus.rdData[7:6] == {ackSync, extGrantRequestN})
    else $error("arbitration status wrong");

  a_board_data: assert property (
    granted && !brdDir_r |=> mportOe[7:5] == 3'b111
      && mportOut[7:5] == $past(brdData_r))
    else $error("board data not driven");

  a_board_strobe: assert property (
    granted |=> mportOut[4:3] == ~{$past(board_strobe_r), $past(board_select_r)})
    else $error("strobe or select level wrong");

  a_parity_dir: assert property (
    granted && !brdDir_r |=> mportParityOe && !mportParityOut)
    else $error("parity line not low for output");

  a_board_low: assert property (
    bus.rdEn && bus.rdIdx == `MPSRC_IDX_BOARD |-> bus.rdData[1:0] == 2'b00)
    else $error("board low bits not zero");

  a_release_port: assert property (
    !reqSel_r |=> state_r == MPSRC_IDLE && extGrantRequestN
      ##1 mportOe == 8'h00)
    else $error("port not released");
endmodule

// File: bench/mpsrc_far_model.sv
module mpsrc_far_model
#(
  parameter logic [7:0] RomData = 8'hb4,
  parameter logic [2:0] BoardData = 3'h3
)
(
  // Arbiter side
  input wire logic linkClk,
  input wire logic ackHold,
  input wire logic extGrantRequestN,
  output logic extGrantAckN,
  // Memory-port lines
  input wire logic [7:0] mportOut,
  input wire logic [7:0] mportOe,
  input wire logic mportParityOut,
  input wire logic romSelectOut,
  input wire logic romSelectOe,
  output logic [7:0] mportIn,
  // Seen by the bench
  output logic [7:0] romShiftIn,
  output logic [2:0] boardLatch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] floatPat = 8'h5a;
  logic [2:0] bitIdx = 3'h0;
  logic [7:0] base;
  logic romCk;
  logic boardRead;

  initial
  begin
    extGrantAckN = 1'b1;
    romShiftIn = 8'h00;
    boardLatch = 3'h0;
  end

  // Arbiter answers on its own clock; hold models a slow grant
  always @(posedge linkClk)
  begin
    extGrantAckN <= extGrantRequestN | ackHold;
    floatPat <= ~floatPat;
  end

  // Undriven lines never keep their last level
  assign romCk = mportOe[2] & mportOut[2] & romSelectOut & romSelectOe;
  assign boardRead = mportOe[3] & ~mportOut[3] & mportParityOut;
  always_comb
  begin
    base = floatPat;
    if (romSelectOut && romSelectOe)
      base[0] = RomData[~bitIdx];
    if (boardRead)
      base[7:5] = BoardData;
  end
  assign mportIn = (mportOut & mportOe) | (base & ~mportOe);

  // Serial ROM shifts on the rising serial clock
  always @(posedge romCk)
  begin
    romShiftIn <= {romShiftIn[6:0], mportOut[1]};
    bitIdx <= bitIdx + 3'h1;
  end

  // Board logic takes its data only as a real strobe ends, while selected
  always @(posedge mportOut[4])
  begin
    if (mportOe[4] && mportOe[3] && !mportOut[3])
      boardLatch <= mportOut[7:5];
  end
endmodule

// File: bench/mport_serial_rom_board_ctl_bench.sv
`include "mpsrc_params.svh"

module mport_serial_rom_board_ctl_bench import mpsrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] Brd = {2'b00, `MPSRC_IDX_BOARD, 2'b00};
  localparam logic [11:0] Rom = {2'b00, `MPSRC_IDX_ROM, 2'b00};
  localparam logic [11:0] Hole = 12'h070;
  localparam logic [7:0] RomBits = 8'hb4;
  logic sys_clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic sramRomBusy = 1'b0;
  logic ackHold = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  mpsrc_resp_t bresp, rresp, rsp;
  logic [31:0] rdata, rv;
  logic extGrantAckN, extGrantRequestN;
  logic [7:0] mportIn, mportOut, mportOe, romShiftIn;
  logic mportParityOut, mportParityOe, romSelectOut, romSelectOe;
  logic [2:0] boardLatch;
  logic [9:0] oeAll;
  assign oeAll = {mportOe, mportParityOe, romSelectOe};
  int miscompares = 0;
  int samplesChecked = 0;
  int i;
  time t0;

  mport_serial_rom_board_ctl uut
  (
    .sys_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sramRomBusy,
    .extGrantAckN, .extGrantRequestN, .mportIn, .mportOut, .mportOe,
    .mportParityOut, .mportParityOe, .romSelectOut, .romSelectOe
  );

  mpsrc_far_model #(.RomData(RomBits), .BoardData(3'h3)) far
  (
    .linkClk, .ackHold, .extGrantRequestN, .extGrantAckN, .mportOut,
    .mportOe, .mportParityOut, .romSelectOut, .romSelectOe, .mportIn,
    .romShiftIn, .boardLatch
  );

  // Clocks; the link clock is unrelated in phase
  initial
    forever #5 sys_clk = ~sys_clk;
  initial
  begin
    #3;
    forever #80 linkClk = ~linkClk;
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready levels are sampled mid-cycle, so they equal the edge value
  task automatic axiWrite(input logic [11:0] a, input logic [7:0] d,
    output mpsrc_resp_t r);
    logic aw, w, b;
    int n;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50)
    begin
      @(negedge sys_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      n++;
    end
    check("write done", 32'h1, {31'h0, b});
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
    output mpsrc_resp_t r);
    logic ar, got;
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    got = 1'b0;
    n = 0;
    while (!got && n < 50)
    begin
      @(negedge sys_clk);
      ar = arvalid & arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ar)
        arvalid <= 1'b0;
      n++;
    end
    check("read done", 32'h1, {31'h0, got});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    axiWrite(a, d, rsp);
    check("bresp", {30'h0, MPSRC_OKAY}, {30'h0, rsp});
  endtask

  task automatic rdChk(input string what, input logic [11:0] a,
    input logic [7:0] m, e);
    axiRead(a, rv, rsp);
    check(what, {MPSRC_OKAY, 22'h0, e & m}, {rsp, rv[29:8], rv[7:0] & m});
  endtask

  // Poll the ready bit as a driver would
  task automatic waitReady();
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[4] !== 1'b1 && n < 60)
    begin
      axiRead(Rom, rv, rsp);
      n++;
    end
    check("ready poll", 32'h1, {31'h0, rv[4]});
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs a little over a thousand cycles
  initial
  begin
    #200000;
    miscompares++;
    testDone();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdChk("board reset", Brd, 8'hff, 8'h00);
    rdChk("rom reset", Rom, 8'hef, 8'hc0);
    check("enables", 32'h0, {22'h0, oeAll});
    axiWrite(Hole, 8'hff, rsp);
    check("hole bresp", {30'h0, MPSRC_SLVERR}, {30'h0, rsp});
    axiRead(Hole, rv, rsp);
    check("hole read", {MPSRC_SLVERR, 30'h0}, {rsp, rv[29:0]});
    wr(Brd, 8'hff);
    rdChk("board low bits", Brd, 8'hff, 8'hfc);
    wr(Brd, 8'h00);
    wr(Rom, 8'h00);
    t0 = $time;
    rdChk("ready cleared", Rom, 8'h10, 8'h00);
    waitReady();
    check("ready delay", 32'h1,
      {31'h0, ($time - t0) inside {[790:900]}});
    // Empty byte lane stores nothing but still restarts the timer
    wstrb <= 4'h0;
    wr(Rom, 8'h2e);
    rdChk("no byte lane", Rom, 8'h3e, 8'h00);
    wstrb <= 4'hf;
    waitReady();
    sramRomBusy <= 1'b1;
    ackHold <= 1'b1;
    wr(Rom, 8'h2e);
    repeat (20) @(posedge sys_clk);
    check("request busy", 32'h1, {31'h0, extGrantRequestN});
    sramRomBusy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("request", 32'h0, {31'h0, extGrantRequestN});
    repeat (100) @(posedge sys_clk);
    rdChk("no grant", Rom, 8'hd0, 8'h80);
    check("undriven", 32'h0, {22'h0, oeAll});
    wr(Rom, 8'h20);
    ackHold <= 1'b0;
    waitReady();
    check("granted", 32'h3fb, {22'h0, oeAll});
    check("parity", 32'h0, {31'h0, mportParityOut});
    rdChk("grant status", Rom, 8'hc0, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(Rom, {6'b001010, i[0], 1'b0});
      waitReady();
      rdChk("serial in", Rom, 8'h01, {7'h0, RomBits[7 - i]});
      wr(Rom, {6'b001011, i[0], 1'b0});
      repeat (3) @(posedge sys_clk);
      check("ck do", {30'h0, 1'b1, i[0]}, {30'h0, mportOut[2:1]});
      check("cs", 32'h1, {31'h0, romSelectOut});
      waitReady();
    end
    check("rom shift", 32'h5, {28'h0, romShiftIn[3:0]});
    wr(Rom, 8'h20);
    repeat (3) @(posedge sys_clk);
    check("ck do cs off", 32'h0,
      {29'h0, mportOut[2:1], romSelectOut});
    wr(Brd, 8'ha8);
    repeat (3) @(posedge sys_clk);
    check("board out", 32'h16, {27'h0, mportOut[7:3]});
    wr(Brd, 8'hb8);
    repeat (3) @(posedge sys_clk);
    check("strobe on", 32'h0, {31'h0, mportOut[4]});
    wr(Brd, 8'ha8);
    repeat (3) @(posedge sys_clk);
    check("strobe off", 32'h1, {31'h0, mportOut[4]});
    check("board latch", 32'h5, {29'h0, boardLatch});
    wr(Brd, 8'h0c);
    repeat (10) @(posedge sys_clk);
    check("read dir", 32'h1,
      {28'h0, mportOe[7:5], mportParityOut});
    rdChk("board in", Brd, 8'hff, 8'h6c);
    sramRomBusy <= 1'b1;
    repeat (50) @(posedge sys_clk);
    check("port kept", 32'h1e, {26'h0, extGrantRequestN, mportOe[4:0]});
    wr(Rom, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("released", 32'h400, {21'h0, extGrantRequestN, oeAll});
    testDone();
  end
endmodule
